//--- core/ifg_core.sv
// Notes on behaviour
// - Every instruction runs the first fetch cycle
// - Second word cycle only for double-word format
// - Indirect cycle only for indirect double-word
// - Format bit gives length; nonzero tag indexes
// - Fetch bits 0-7 to control, 8-15 displacement
// - Opcode, format-tag, modifier, shift count fields
// - Instruction register copied to address register first
// - Fetched instruction word written back after read
// - Indexed displacement sign-extended from bit 8
// - Unindexed single word: register plus displacement
// - Indexed: chosen index register goes to accumulator
// - Unindexed second word replaces accumulator
// - Indexed second word adds to accumulator
// - Bit 8 of double word marks indirect
// - Indirect cycle reads direct address into accumulator
// - Only one level of indirection ever
// - Execution follows instruction cycles with no gap
// - Execution cycle flags plus shift counter
// - Listed ops finish without execution cycles
// - Set next cycle flag, clear previous together
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ifg_params.svh"

module ifg_core
  import ifg_pkg::*;
(
  input  wire logic         MCLK,
  input  wire logic         RSTN,
  input  wire logic         CE,
  input  wire logic         PSEL,
  input  wire logic         PENABLE,
  input  wire logic         PWRITE,
  input  wire logic [7:0]   PADDR,
  input  wire logic [31:0]  PWDATA,
  output logic [31:0]       PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  output ifg_mem_cmd_t      MEM_CMD,
  input  wire logic         MEM_ACK,
  input  wire logic [15:0]  MEM_RDATA,
  output ifg_decode_t       DECODE,
  output logic [15:0]       EA,
  output logic [1:0]        EXEC_CYC,
  output logic              INSTR_DONE
);

  ifg_regs_t   s_q;
  ifg_regs_t   s_d;
  logic        acc_ok;
  logic        wr_ok;
  logic        addr_ok;
  logic        ack;
  logic        no_exec;
  logic [15:0] idx_val;
  logic [15:0] disp_ext;
  logic [15:0] fetch_base;
  ifg_decode_t fdec;

  assign acc_ok  = PSEL && PENABLE && CE;
  assign wr_ok   = acc_ok && PWRITE && addr_ok;
  assign ack     = MEM_ACK && CE;

  always_comb
  begin
    case (PADDR)
      `IFG_OFS_CTRL, `IFG_OFS_STATUS, `IFG_OFS_IREG, `IFG_OFS_ACC,
      `IFG_OFS_XR1, `IFG_OFS_XR2, `IFG_OFS_XR3, `IFG_OFS_NOEXEC,
      `IFG_OFS_TWOE, `IFG_OFS_DECODE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Field split of the word arriving from storage
  always_comb
  begin
    fdec.opcode_field      = MEM_RDATA[`IFG_OPC_HI:`IFG_OPC_LO];
    fdec.fmt               = MEM_RDATA[`IFG_FMT_BIT];
    fdec.tag               = MEM_RDATA[`IFG_TAG_HI:`IFG_TAG_LO];
    fdec.modifier_field    = MEM_RDATA[`IFG_MDF_HI:`IFG_MDF_LO];
    fdec.shift_count_field = MEM_RDATA[`IFG_SHC_HI:`IFG_SHC_LO];
  end

  // Index register selection
  always_comb
  begin
    if (fdec.tag == 2'b00)
    begin
      idx_val = 16'h0000;
    end
    else
    begin
      idx_val = s_q.xr[fdec.tag - 2'b01];
    end
  end

  // Displacement, sign-extended only when indexed
  always_comb
  begin
    if (fdec.tag != 2'b00)
    begin
      disp_ext = {{8{MEM_RDATA[`IFG_DISP_HI]}},
                  MEM_RDATA[`IFG_DISP_HI:`IFG_DISP_LO]};
    end
    else
    begin
      disp_ext = {8'h00, MEM_RDATA[`IFG_DISP_HI:`IFG_DISP_LO]};
    end
  end

  // Base for the accumulator in the first cycle
  always_comb
  begin
    if (fdec.tag == 2'b00)
    begin
      fetch_base = s_q.ireg + 16'h0001;
    end
    else
    begin
      fetch_base = idx_val;
    end
  end

  assign no_exec = s_q.noexec[s_q.dec.opcode_field] ||
                   (s_q.dec.opcode_field == `IFG_LDX_OPC &&
                    s_q.dec.tag == 2'b00);

  always_comb
  begin
    s_d = s_q;
    if (CE)
    begin
      s_d.done = 1'b0;
      if (PSEL)
      begin
        case (PADDR)
          `IFG_OFS_CTRL:   s_d.prdata = {30'h0, s_q.run, 1'b0};
          `IFG_OFS_STATUS: s_d.prdata = {26'h0, s_q.ecyc, s_q.st};
          `IFG_OFS_IREG:   s_d.prdata = {16'h0, s_q.ireg};
          `IFG_OFS_ACC:    s_d.prdata = {16'h0, s_q.acc};
          `IFG_OFS_XR1:    s_d.prdata = {16'h0, s_q.xr[0]};
          `IFG_OFS_XR2:    s_d.prdata = {16'h0, s_q.xr[1]};
          `IFG_OFS_XR3:    s_d.prdata = {16'h0, s_q.xr[2]};
          `IFG_OFS_NOEXEC: s_d.prdata = s_q.noexec;
          `IFG_OFS_TWOE:   s_d.prdata = s_q.twoe;
          `IFG_OFS_DECODE: s_d.prdata = {16'h0, s_q.dec};
          default:         s_d.prdata = 32'h0;
        endcase
      end
      case (s_q.st)
        IFG_IDLE:
        begin
          if (s_q.run || (wr_ok && PADDR == `IFG_OFS_CTRL && PWDATA[`IFG_CTRL_START]))
          begin
            s_d.mem.addr = s_q.ireg;
            s_d.mem.req  = 1'b1;
            s_d.mem.we   = 1'b0;
            s_d.st       = IFG_FETCH_RD;
          end
        end
        IFG_FETCH_RD:
        begin
          if (ack)
          begin
            s_d.sbr       = MEM_RDATA;
            s_d.dec       = fdec;
            s_d.disp      = disp_ext;
            s_d.ireg      = s_q.ireg + 16'h0001;
            if (fdec.fmt)
            begin
              s_d.acc = fetch_base;
            end
            else
            begin
              s_d.acc = fetch_base + disp_ext;
            end
            s_d.mem.we    = 1'b1;
            s_d.mem.wdata = MEM_RDATA;
            s_d.st        = IFG_FETCH_WB;
          end
        end
        IFG_FETCH_WB:
        begin
          if (ack)
          begin
            if (s_q.dec.fmt)
            begin
              s_d.mem.addr = s_q.ireg;
              s_d.mem.we   = 1'b0;
              s_d.st       = IFG_WORD2_RD;
            end
            else
            begin
              s_d.mem.req = 1'b0;
              s_d.mem.we  = 1'b0;
              s_d.st      = no_exec ? IFG_IDLE : IFG_EXEC;
              s_d.ecyc    = no_exec ? 2'b00 : 2'b01;
              s_d.done    = no_exec;
            end
          end
        end
        IFG_WORD2_RD:
        begin
          if (ack)
          begin
            s_d.sbr  = MEM_RDATA;
            s_d.ireg = s_q.ireg + 16'h0001;
            if (s_q.dec.tag == 2'b00)
            begin
              s_d.acc = MEM_RDATA;
            end
            else
            begin
              s_d.acc = s_q.acc + MEM_RDATA;
            end
            s_d.mem.we    = 1'b1;
            s_d.mem.wdata = MEM_RDATA;
            s_d.st        = IFG_WORD2_WB;
          end
        end
        IFG_WORD2_WB:
        begin
          if (ack)
          begin
            if (s_q.dec.modifier_field[`IFG_IND_BIT - `IFG_MDF_LO])
            begin
              s_d.mem.addr = s_q.acc;
              s_d.mem.we   = 1'b0;
              s_d.st       = IFG_INDIR_RD;
            end
            else
            begin
              s_d.mem.req = 1'b0;
              s_d.mem.we  = 1'b0;
              s_d.st      = no_exec ? IFG_IDLE : IFG_EXEC;
              s_d.ecyc    = no_exec ? 2'b00 : 2'b01;
              s_d.done    = no_exec;
            end
          end
        end
        IFG_INDIR_RD:
        begin
          if (ack)
          begin
            s_d.sbr       = MEM_RDATA;
            s_d.disp      = MEM_RDATA;
            s_d.acc       = MEM_RDATA;
            s_d.mem.we    = 1'b1;
            s_d.mem.wdata = MEM_RDATA;
            s_d.st        = IFG_INDIR_WB;
          end
        end
        IFG_INDIR_WB:
        begin
          if (ack)
          begin
            s_d.mem.req = 1'b0;
            s_d.mem.we  = 1'b0;
            s_d.st      = no_exec ? IFG_IDLE : IFG_EXEC;
            s_d.ecyc    = no_exec ? 2'b00 : 2'b01;
            s_d.done    = no_exec;
          end
        end
        IFG_EXEC:
        begin
          if (s_q.dec.shift_count_field != 6'h00)
          begin
            s_d.dec.shift_count_field = s_q.dec.shift_count_field - 6'h01;
          end
          if (s_q.ecyc[0] && s_q.twoe[s_q.dec.opcode_field])
          begin
            s_d.ecyc = 2'b10;
          end
          else
          begin
            s_d.ecyc = 2'b00;
            s_d.done = 1'b1;
            s_d.st   = IFG_IDLE;
          end
        end
        default:
        begin
          s_d.st      = IFG_IDLE;
          s_d.mem.req = 1'b0;
          s_d.ecyc    = 2'b00;
        end
      endcase
      if (wr_ok)
      begin
        case (PADDR)
          `IFG_OFS_CTRL:   s_d.run    = PWDATA[`IFG_CTRL_RUN];
          `IFG_OFS_IREG:   s_d.ireg   = PWDATA[15:0];
          `IFG_OFS_XR1:    s_d.xr[0]  = PWDATA[15:0];
          `IFG_OFS_XR2:    s_d.xr[1]  = PWDATA[15:0];
          `IFG_OFS_XR3:    s_d.xr[2]  = PWDATA[15:0];
          `IFG_OFS_NOEXEC: s_d.noexec = PWDATA;
          `IFG_OFS_TWOE:   s_d.twoe   = PWDATA;
          default:         s_d.run    = s_d.run;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_q        <= '0;
      s_q.st     <= IFG_IDLE;
      s_q.ireg   <= `IFG_RST_WORD;
      s_q.noexec <= `IFG_RST_NOEXEC;
      s_q.twoe   <= `IFG_RST_TWOE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PRDATA     = s_q.prdata;
  assign PREADY     = CE;
  assign PSLVERR    = PSEL && PENABLE && !addr_ok;
  assign MEM_CMD    = s_q.mem;
  assign DECODE     = s_q.dec;
  assign EA         = s_q.acc;
  assign EXEC_CYC   = s_q.ecyc;
  assign INSTR_DONE = s_q.done;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  chk_fetch_addr_ireg: assert property (
    (s_q.st == IFG_IDLE && s_d.st == IFG_FETCH_RD) |=>
      (MEM_CMD.addr == $past(s_q.ireg) && MEM_CMD.req && !MEM_CMD.we))
    else $error("Fetch not addressed from instruction register");

  chk_single_no_second: assert property (
    (s_q.st == IFG_FETCH_WB && ack && !s_q.dec.fmt) |=> (s_q.st != IFG_WORD2_RD))
    else $error("Single word entered second word cycle");

  chk_double_second: assert property (
    (s_q.st == IFG_FETCH_WB && ack && s_q.dec.fmt) |=>
      (s_q.st == IFG_WORD2_RD && MEM_CMD.addr == $past(s_q.ireg)))
    else $error("Double word missed second word cycle");

  chk_indirect_only_double: assert property (
    (s_q.st == IFG_INDIR_RD) |-> (s_q.dec.fmt && s_q.dec.modifier_field[1]))
    else $error("Indirect cycle without indirect double word");

  chk_fetch_write_back: assert property (
    (s_q.st == IFG_FETCH_RD && ack) |=>
      (MEM_CMD.we && MEM_CMD.wdata == $past(MEM_RDATA) &&
       MEM_CMD.addr == $past(MEM_CMD.addr)))
    else $error("Instruction word not written back");

  chk_disp_sign_ext: assert property (
    (s_q.st == IFG_FETCH_RD && ack && fdec.tag != 2'b00) |=>
      (s_q.disp[15:8] == {8{s_q.disp[7]}}))
    else $error("Displacement not sign-extended");

  chk_single_unindexed_ea: assert property (
    (s_q.st == IFG_FETCH_RD && ack && !fdec.fmt && fdec.tag == 2'b00) |=>
      (s_q.acc == $past(s_q.ireg) + 16'h0001 + {8'h00, $past(MEM_RDATA[7:0])}))
    else $error("Single word effective address wrong");

  chk_second_word_acc: assert property (
    (s_q.st == IFG_WORD2_RD && ack) |=>
      (s_q.acc == (($past(s_q.dec.tag) == 2'b00) ? $past(MEM_RDATA) :
                   $past(s_q.acc) + $past(MEM_RDATA))))
    else $error("Second word accumulator wrong");

  chk_one_indirect_level: assert property (
    (s_q.st == IFG_INDIR_WB && ack) |=> (s_q.st != IFG_INDIR_RD))
    else $error("Second level of indirection");

  chk_noexec_ops_skip: assert property (
    (s_q.st == IFG_EXEC) |-> !no_exec)
    else $error("Execution cycle for op that needs none");

  chk_ce_hold_state: assert property (
    (!CE) |=> (s_q == $past(s_q)))
    else $error("State changed while clock enable low");

  cov_single_word: cover property (
    s_q.st == IFG_FETCH_WB ##1 s_q.st == IFG_IDLE);
  cov_double_indirect: cover property (
    s_q.st == IFG_INDIR_WB ##1 s_q.st == IFG_EXEC);
  cov_two_exec: cover property (
    s_q.ecyc == 2'b01 ##1 s_q.ecyc == 2'b10);

endmodule // ifg_core

`default_nettype wire

//--- core/ifg_params.svh
`ifndef IFG_PARAMS_SVH
`define IFG_PARAMS_SVH

// Register byte offsets on the APB
`define IFG_OFS_CTRL    8'h00
`define IFG_OFS_STATUS  8'h04
`define IFG_OFS_IREG    8'h08
`define IFG_OFS_ACC     8'h0c
`define IFG_OFS_XR1     8'h10
`define IFG_OFS_XR2     8'h14
`define IFG_OFS_XR3     8'h18
`define IFG_OFS_NOEXEC  8'h1c
`define IFG_OFS_TWOE    8'h20
`define IFG_OFS_DECODE  8'h24

// Control register bits
`define IFG_CTRL_START  0
`define IFG_CTRL_RUN    1

// Instruction word fields; word bit 0 is the msb (bit 15 here)
`define IFG_OPC_HI      15
`define IFG_OPC_LO      11
`define IFG_FMT_BIT     10
`define IFG_TAG_HI      9
`define IFG_TAG_LO      8
`define IFG_MDF_HI      7
`define IFG_MDF_LO      6
`define IFG_IND_BIT     7
`define IFG_SHC_HI      5
`define IFG_SHC_LO      0
`define IFG_DISP_HI     7
`define IFG_DISP_LO     0

// Reset values and the LDX opcode
`define IFG_RST_WORD    16'h0000
`define IFG_RST_NOEXEC  32'h0000_0000
`define IFG_RST_TWOE    32'h0000_0000
`define IFG_LDX_OPC     5'h0c

`endif

//--- core/ifg_pkg.sv
package ifg_pkg;

  typedef enum logic [3:0] {
    IFG_IDLE     = 4'h0,
    IFG_FETCH_RD = 4'h1,
    IFG_FETCH_WB = 4'h3,
    IFG_WORD2_RD = 4'h2,
    IFG_WORD2_WB = 4'h6,
    IFG_INDIR_RD = 4'h7,
    IFG_INDIR_WB = 4'h5,
    IFG_EXEC     = 4'h4
  } ifg_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ifg_mem_cmd_t;

  typedef struct packed {
    logic [4:0] opcode_field;
    logic       fmt;
    logic [1:0] tag;
    logic [1:0] modifier_field;
    logic [5:0] shift_count_field;
  } ifg_decode_t;

  typedef struct packed {
    ifg_state_t     st;
    logic [15:0]    ireg;
    logic [15:0]    acc;
    logic [15:0]    sbr;
    logic [15:0]    disp;
    ifg_decode_t    dec;
    logic [2:0][15:0] xr;
    logic [31:0]    noexec;
    logic [31:0]    twoe;
    logic [1:0]     ecyc;
    logic           run;
    logic           done;
    ifg_mem_cmd_t   mem;
    logic [31:0]    prdata;
  } ifg_regs_t;

endpackage

//--- dv/ifg_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module ifg_mem_model
  import ifg_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire ifg_mem_cmd_t cmd,
  input  wire logic         slow,
  output logic              ack,
  output logic [15:0]       rdata
);
  logic [15:0] mem [0:65535];
  logic [1:0]  wt_q;
  logic [15:0] first_addr;
  int          nrd;
  int          nwr;

  // Slow mode stalls each command three cycles; idle data toggles every cycle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack   <= 1'b0;
      wt_q  <= 2'h0;
      rdata <= 16'h5a5a;
    end
    else if (ack)
    begin
      ack   <= 1'b0;
      rdata <= ~rdata;
    end
    else if (cmd.req && (!slow || wt_q == 2'h3))
    begin
      ack  <= 1'b1;
      wt_q <= 2'h0;
      if (cmd.we)
      begin
        mem[cmd.addr] <= cmd.wdata;
        nwr           <= nwr + 1;
      end
      else
      begin
        rdata         <= mem[cmd.addr];
        mem[cmd.addr] <= 16'h0000;
        if (nrd == 0)
          first_addr <= cmd.addr;
        nrd <= nrd + 1;
      end
    end
    else
    begin
      wt_q  <= cmd.req ? wt_q + 2'h1 : 2'h0;
      rdata <= ~rdata;
    end
  end

  task put(input logic [15:0] a, input logic [15:0] d);
    mem[a] = d;
  endtask

  task clr;
    nrd = 0;
    nwr = 0;
  endtask
endmodule // ifg_mem_model

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ifg_params.svh"

module tb_top
  import ifg_pkg::*;
();
  typedef struct {
    logic [15:0] ir, w1, w2, ptr, iw, ea;
    int          nrd, nex;
  } ifg_row_t;

  logic         mclk   = 1'b0;
  logic         rstn   = 1'b0;
  logic         ce     = 1'b1;
  logic         psel   = 1'b0;
  logic         pen    = 1'b0;
  logic         pwr    = 1'b0;
  logic         slow   = 1'b0;
  logic [7:0]   paddr  = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic [31:0]  q;
  logic         pready;
  logic         pslverr;
  logic         perr;
  logic         ack;
  logic         done;
  logic [15:0]  rdata;
  logic [15:0]  ea;
  logic [1:0]   ecyc;
  ifg_mem_cmd_t cmd;
  ifg_decode_t  dec;
  int           mismatches = 0;
  int           cmp_count  = 0;
  int           cyc        = 0;
  int           nex        = 0;

  ifg_row_t rows [11] = '{
    '{16'h0100, 16'h1010, '0, '0, '0, 16'h0111, 1, 1},
    '{16'h0110, 16'h11f0, '0, '0, '0, 16'h01f0, 1, 1},
    '{16'h0120, 16'h1305, '0, '0, '0, 16'h0305, 1, 1},
    '{16'h0130, 16'h1400, 16'h0abc, '0, '0, 16'h0abc, 2, 1},
    '{16'h0140, 16'h1600, 16'h0034, '0, '0, 16'h1034, 2, 1},
    '{16'h0150, 16'h1480, 16'h0050, 16'h0050, 16'h0777, 16'h0777, 3, 1},
    '{16'h0160, 16'h1580, 16'h0010, 16'h0210, 16'h8000, 16'h8000, 3, 1},
    '{16'h0170, 16'h6008, '0, '0, '0, 16'h0179, 1, 0},
    '{16'h0180, 16'h1820, '0, '0, '0, 16'h01a1, 1, 0},
    '{16'h0190, 16'h2001, '0, '0, '0, 16'h0192, 1, 2},
    '{16'h01a0, 16'h1080, '0, '0, '0, 16'h0221, 1, 1}};

  ifg_core ifg_core_i (.MCLK(mclk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEM_CMD(cmd), .MEM_ACK(ack), .MEM_RDATA(rdata), .DECODE(dec),
    .EA(ea), .EXEC_CYC(ecyc), .INSTR_DONE(done));

  ifg_mem_model mem_i (.clk(mclk), .rst_n(rstn), .cmd(cmd), .slow(slow), .ack(ack),
    .rdata(rdata));

  always #50 mclk = ~mclk;

  // Cycle watchdog and execution cycle tally
  always @(posedge mclk)
  begin
    cyc++;
    if (ecyc !== 2'b00)
      nex++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up;
    end
  end

  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    q    = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task run(input ifg_row_t r, input logic twice);
    int n;
    logic [5:0] sc;
    mem_i.put(r.ir, r.w1);
    mem_i.put(r.ir + 16'h1, r.w2);
    mem_i.put(r.ptr, r.iw);
    apb(1'b1, `IFG_OFS_IREG, {16'h0, r.ir});
    mem_i.clr();
    nex = 0;
    apb(1'b1, `IFG_OFS_CTRL, 32'h1);
    if (twice)
      apb(1'b1, `IFG_OFS_CTRL, 32'h1);
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    if (done !== 1'b1)
    begin
      mismatches++;
      wrap_up;
    end
    repeat (4) @(posedge mclk);
    chk({16'h0, ea}, {16'h0, r.ea});
    chk(mem_i.nrd, r.nrd);
    chk({16'h0, mem_i.first_addr}, {16'h0, r.ir});
    chk(mem_i.nwr, r.nrd);
    chk({16'h0, mem_i.mem[r.ir]}, {16'h0, r.w1});
    sc = (r.w1[5:0] > r.nex) ? r.w1[5:0] - 6'(r.nex) : 6'h00;
    chk({16'h0, dec}, {16'h0, r.w1[15:6], sc});
    chk(nex, r.nex);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b0, 8'h04 * i[7:0], 32'h0);
      if (i < 10)
        chk(q, (i == 2) ? 32'h0 : 32'h0);
    end
    $display("test reset values done");
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, `IFG_OFS_ACC, 32'h1234);
    apb(1'b0, `IFG_OFS_ACC, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, perr}, 32'h0);
    apb(1'b1, `IFG_OFS_XR1, 32'h0200);
    apb(1'b1, `IFG_OFS_XR2, 32'h1000);
    apb(1'b1, `IFG_OFS_XR3, 32'h0300);
    apb(1'b1, `IFG_OFS_NOEXEC, 32'h8);
    apb(1'b1, `IFG_OFS_TWOE, 32'h10);
    apb(1'b0, `IFG_OFS_XR2, 32'h0);
    chk(q, 32'h1000);
    apb(1'b0, `IFG_OFS_NOEXEC, 32'h0);
    chk(q, 32'h8);
    $display("test registers done");
    foreach (rows[i])
    begin
      run(rows[i], 1'b0);
      $display("test row %0d done", i);
    end
    slow <= 1'b1;
    run(rows[6], 1'b0);
    run(rows[0], 1'b1);
    slow <= 1'b0;
    $display("test slow storage done");
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    chk({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    $display("test clock enable done");
    mem_i.put(16'h01b0, 16'h1820);
    mem_i.put(16'h01b1, 16'h1820);
    mem_i.put(16'h01b2, 16'h1820);
    apb(1'b1, `IFG_OFS_IREG, 32'h01b0);
    mem_i.clr();
    apb(1'b1, `IFG_OFS_CTRL, 32'h2);
    apb(1'b0, `IFG_OFS_CTRL, 32'h0);
    chk(q, 32'h2);
    apb(1'b1, `IFG_OFS_CTRL, 32'h0);
    repeat (8) @(posedge mclk);
    apb(1'b0, `IFG_OFS_IREG, 32'h0);
    chk(q, 32'h01b2);
    chk(mem_i.nrd, 2);
    $display("test run mode done");
    mem_i.put(16'h0130, 16'h1400);
    apb(1'b1, `IFG_OFS_IREG, 32'h0130);
    apb(1'b1, `IFG_OFS_CTRL, 32'h1);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({16'h0, ea}, 32'h0);
    chk({31'h0, cmd.req}, 32'h0);
    rstn <= 1'b1;
    apb(1'b0, `IFG_OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    $display("test mid run reset done");
    wrap_up;
  end
endmodule // tb_top

`default_nettype wire
